// ===== gdpg_regs.vh
/*
 * register map, field positions, reset values and mode encodings of the
 * gated delayed pulse generator.
 * assumes: included by bare name from the design files; definitions only.
 */
`ifndef GDPG_REGS_VH
`define GDPG_REGS_VH

// ----------------------------------------------------------------------
// register byte offsets (low address byte, word aligned)
// ----------------------------------------------------------------------
`define GDPG_ADDR_W          8
`define GDPG_ADDR_CTRL       8'h00
`define GDPG_ADDR_DELAY      8'h04
`define GDPG_ADDR_WIDTH      8'h08
`define GDPG_ADDR_CMD        8'h0C
`define GDPG_ADDR_STATUS     8'h10
`define GDPG_ADDR_COUNT      8'h14

// ----------------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------------
`define GDPG_CTRL_W          5
`define GDPG_CTRL_GATE_LSB   0
`define GDPG_CTRL_GATE_MSB   2
`define GDPG_CTRL_POL_BIT    3
`define GDPG_CTRL_TB_BIT     4
`define GDPG_CTRL_RST        5'h00

// ----------------------------------------------------------------------
// command register bits (write only, read as zero)
// ----------------------------------------------------------------------
`define GDPG_CMD_START_BIT   0
`define GDPG_CMD_STOP_BIT    1

// ----------------------------------------------------------------------
// status register fields
// ----------------------------------------------------------------------
`define GDPG_STAT_STATE_LSB  0
`define GDPG_STAT_STATE_MSB  2
`define GDPG_STAT_OUT_BIT    3
`define GDPG_STAT_BUSY_BIT   4
`define GDPG_STAT_DONE_BIT   5

// ----------------------------------------------------------------------
// gate selections, polarity, timebase
// ----------------------------------------------------------------------
`define GDPG_GATE_NONE       3'h0
`define GDPG_GATE_HIGH       3'h1
`define GDPG_GATE_LOW        3'h2
`define GDPG_GATE_RISE       3'h3
`define GDPG_GATE_FALL       3'h4
`define GDPG_POL_HIGH_PULSE  1'h0
`define GDPG_TB_INTERNAL     1'h0

// ----------------------------------------------------------------------
// counts and reset values
// ----------------------------------------------------------------------
`define GDPG_CNT_RST         32'h0000_0000
`define GDPG_CNT_ONE         32'h0000_0001
`define GDPG_MIN_INT_CYCLES  32'h0000_0003
`define GDPG_MIN_EXT_CYCLES  32'h0000_0001
`define GDPG_WORD_ZERO       32'h0000_0000

`endif

// ===== gdpg_edge_det.v
/*
 * per-bit rising and falling edge detector for synchronous inputs.
 * assumes: inputs already synchronous to ref_clk; ce freezes the history.
 */
`timescale 1ns/1ps
`default_nettype none

module gdpg_edge_det #(
   parameter N = 2
) (
   input  wire         ref_clk,  // system clock
   input  wire         rstn,     // async reset, active low
   input  wire         ce,       // clock enable, freezes history when low
   input  wire [N-1:0] sig,      // sampled inputs
   output wire [N-1:0] rise,     // one-cycle rising edge marks
   output wire [N-1:0] fall      // one-cycle falling edge marks
);

   // ----------------------------------------------------------------------
   // one history flop per bit
   // ----------------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < N; g = g + 1) begin : g_bit
         reg prev_ff;

         // history resets low, so a pin high at release reads as a rise
         always @(posedge ref_clk or negedge rstn) begin
            if (!rstn) begin
               prev_ff <= 1'b0;
            end else if (ce) begin
               prev_ff <= sig[g];
            end
         end

         // edges only count while enabled, matching the frozen history
         assign rise[g] = ce & sig[g] & ~prev_ff;
         assign fall[g] = ce & ~sig[g] & prev_ff;
      end
   endgenerate

endmodule // gdpg_edge_det

`default_nettype wire

// ===== gdpg_top.v
/*
 * gated delayed pulse generator: one counter producing a single two-phase
 * pulse (delay then width) after a software start, behind an ahb-lite slave.
 * assumes: single ahb-lite slave whose hreadyout is the bus hready; gate and
 * external timebase pins are synchronous to ref_clk.
 *
// What this block does
// - gate selection 0: start immediately on command
// - selection 1: count only while gate high
// - selection 2: count only while gate low
// - selection 3: wait for rising gate edge
// - selection 4: wait for falling gate edge
// - edge modes emit exactly one pulse
// - polarity 0: low delay, high width
// - polarity 1: high delay, low width
// - phases last programmed delay, width counts
// - timebase 0 internal, 1 external pin
// - zero count, internal timebase: three cycles
 */
`timescale 1ns/1ps
`default_nettype none
`include "gdpg_regs.vh"

module gdpg_top (
   input  wire        ref_clk,                  // 40 mhz system clock
   input  wire        rstn,                     // async reset, active low
   input  wire        ce,                       // clock enable, freezes all state
   input  wire        hsel,                     // ahb slave select
   input  wire [31:0] haddr,                    // ahb address
   input  wire [1:0]  htrans,                   // ahb transfer type
   input  wire        hwrite,                   // ahb write strobe
   input  wire [2:0]  hsize,                    // ahb size, word only
   input  wire [31:0] hwdata,                   // ahb write data
   input  wire        hready,                   // ahb bus ready
   output wire        hreadyout,                // ahb slave ready
   output wire        hresp,                    // ahb response, always okay
   output wire [31:0] hrdata,                   // ahb read data
   input  wire        gate_input,               // gate pin
   input  wire        external_timebase_input,  // external timebase pin
   output wire        pulse_output              // pulse pin
);

   // ----------------------------------------------------------------------
   // states
   // ----------------------------------------------------------------------
   localparam [2:0] S_IDLE  = 3'h0;
   localparam [2:0] S_ARMED = 3'h1;
   localparam [2:0] S_DELAY = 3'h2;
   localparam [2:0] S_WIDTH = 3'h3;
   localparam [2:0] S_DONE  = 3'h4;

   // ----------------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------------
   reg [`GDPG_CTRL_W-1:0] ctrl_ff;
   reg [31:0]             delay_ff;
   reg [31:0]             width_ff;
   reg                    dph_ff;
   reg                    dwr_ff;
   reg [`GDPG_ADDR_W-1:0] daddr_ff;
   reg [31:0]             hrdata_ff;
   reg [31:0]             rd_mux;
   reg [2:0]              state_ff;
   reg [2:0]              nxt_state;
   reg [31:0]             cnt_ff;
   reg [31:0]             nxt_cnt;
   reg                    done_ff;
   reg                    nxt_done;
   reg [2:0]              run_gate_ff;
   reg                    run_pol_ff;
   reg                    run_tb_ff;
   reg [31:0]             run_width_ff;
   reg                    out_ff;
   reg                    nxt_out;
   reg                    gate_ok;
   wire                   acc;
   wire                   wr_en;
   wire                   cmd_start;
   wire                   cmd_stop;
   wire [2:0]             cfg_gate;
   wire                   cfg_pol;
   wire                   cfg_tb;
   wire [1:0]             rise;
   wire [1:0]             fall;
   wire                   gate_rise;
   wire                   gate_fall;
   wire                   ext_rise;
   wire                   tick;
   wire                   advance;
   wire                   edge_hit;
   wire                   edge_mode;
   wire [31:0]            status_word;

   // ----------------------------------------------------------------------
   // effective phase length: a zero request is raised to the minimum
   // ----------------------------------------------------------------------
   function [31:0] eff_len;
      input [31:0] req;
      input        tb;
      begin
         if (req != `GDPG_CNT_RST) begin
            eff_len = req;
         end else if (tb == `GDPG_TB_INTERNAL) begin
            eff_len = `GDPG_MIN_INT_CYCLES;
         end else begin
            // a zero phase would be meaningless, so one tick is the floor
            eff_len = `GDPG_MIN_EXT_CYCLES;
         end
      end
   endfunction

   // ----------------------------------------------------------------------
   // ahb-lite slave
   // ----------------------------------------------------------------------
   // a frozen block holds the bus rather than silently drop an access
   assign hreadyout = ce;
   assign hresp     = 1'b0;
   assign hrdata    = hrdata_ff;
   assign acc       = hsel & htrans[1] & hready;
   assign wr_en     = ce & dph_ff & dwr_ff;

   // address phase capture
   always @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         dph_ff   <= 1'b0;
         dwr_ff   <= 1'b0;
         daddr_ff <= `GDPG_ADDR_CTRL;
      end else if (ce) begin
         dph_ff <= acc;
         if (acc) begin
            dwr_ff   <= hwrite;
            daddr_ff <= haddr[`GDPG_ADDR_W-1:0];
         end
      end
   end

   // status word: state, output level, busy, done
   assign status_word = {26'h0, done_ff, (state_ff != S_IDLE) & (state_ff != S_DONE),
                         out_ff, state_ff};

   // read mux; unmapped offsets and the command register read zero
   always @* begin
      case (haddr[`GDPG_ADDR_W-1:0])
         `GDPG_ADDR_CTRL:   rd_mux = {27'h0, ctrl_ff};
         `GDPG_ADDR_DELAY:  rd_mux = delay_ff;
         `GDPG_ADDR_WIDTH:  rd_mux = width_ff;
         `GDPG_ADDR_STATUS: rd_mux = status_word;
         `GDPG_ADDR_COUNT:  rd_mux = cnt_ff;
         default:           rd_mux = `GDPG_WORD_ZERO;
      endcase
   end

   // read data registered at the address phase, valid through data phase
   always @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         hrdata_ff <= `GDPG_WORD_ZERO;
      end else if (ce && acc && !hwrite) begin
         hrdata_ff <= rd_mux;
      end
   end

   // configuration registers written in the data phase
   always @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         ctrl_ff  <= `GDPG_CTRL_RST;
         delay_ff <= `GDPG_CNT_RST;
         width_ff <= `GDPG_CNT_RST;
      end else if (wr_en) begin
         case (daddr_ff)
            `GDPG_ADDR_CTRL:  ctrl_ff  <= hwdata[`GDPG_CTRL_W-1:0];
            `GDPG_ADDR_DELAY: delay_ff <= hwdata;
            `GDPG_ADDR_WIDTH: width_ff <= hwdata;
            default:          ctrl_ff  <= ctrl_ff;
         endcase
      end
   end

   // command strobes, one cycle each
   assign cmd_start = wr_en & (daddr_ff == `GDPG_ADDR_CMD) & hwdata[`GDPG_CMD_START_BIT];
   assign cmd_stop  = wr_en & (daddr_ff == `GDPG_ADDR_CMD) & hwdata[`GDPG_CMD_STOP_BIT];

   assign cfg_gate = ctrl_ff[`GDPG_CTRL_GATE_MSB:`GDPG_CTRL_GATE_LSB];
   assign cfg_pol  = ctrl_ff[`GDPG_CTRL_POL_BIT];
   assign cfg_tb   = ctrl_ff[`GDPG_CTRL_TB_BIT];

   // ----------------------------------------------------------------------
   // edge detection of gate and external timebase
   // ----------------------------------------------------------------------
   gdpg_edge_det #(
      .N (2)
   ) u_edge (
      .ref_clk (ref_clk),
      .rstn    (rstn),
      .ce      (ce),
      .sig     ({external_timebase_input, gate_input}),
      .rise    (rise),
      .fall    (fall)
   );

   assign gate_rise = rise[0];
   assign gate_fall = fall[0];
   assign ext_rise  = rise[1];

   // ----------------------------------------------------------------------
   // timebase and gate qualification
   // ----------------------------------------------------------------------
   // internal: every enabled clock; external: each rising pin edge
   assign tick = (run_tb_ff == `GDPG_TB_INTERNAL) ? ce : ext_rise;

   // level gate modes pause counting, they do not restart it
   always @* begin
      case (run_gate_ff)
         `GDPG_GATE_HIGH: gate_ok = gate_input;
         `GDPG_GATE_LOW:  gate_ok = ~gate_input;
         default:         gate_ok = 1'b1;
      endcase
   end

   assign advance   = tick & gate_ok;
   assign edge_mode = (cfg_gate == `GDPG_GATE_RISE) | (cfg_gate == `GDPG_GATE_FALL);
   assign edge_hit  = (run_gate_ff == `GDPG_GATE_RISE) ? gate_rise
                                                       : gate_fall;

   // ----------------------------------------------------------------------
   // pulse state machine
   // ----------------------------------------------------------------------
   always @* begin
      nxt_state = state_ff;
      nxt_cnt   = cnt_ff;
      nxt_done  = done_ff;
      case (state_ff)
         S_IDLE: begin
            nxt_state = S_IDLE;
         end
         S_ARMED: begin
            // only the first qualifying edge after start launches the pulse
            if (edge_hit) begin
               nxt_state = S_DELAY;
               nxt_cnt   = eff_len(delay_ff, run_tb_ff);
            end
         end
         S_DELAY: begin
            if (advance) begin
               if (cnt_ff == `GDPG_CNT_ONE) begin
                  nxt_state = S_WIDTH;
                  nxt_cnt   = eff_len(run_width_ff, run_tb_ff);
               end else begin
                  nxt_cnt = cnt_ff - `GDPG_CNT_ONE;
               end
            end
         end
         S_WIDTH: begin
            if (advance) begin
               if (cnt_ff == `GDPG_CNT_ONE) begin
                  nxt_state = S_DONE;
                  nxt_done  = 1'b1;
                  nxt_cnt   = `GDPG_CNT_RST;
               end else begin
                  nxt_cnt = cnt_ff - `GDPG_CNT_ONE;
               end
            end
         end
         S_DONE: begin
            // no re-arm: a further edge never yields a second pulse
            nxt_state = S_DONE;
         end
         default: begin
            nxt_state = S_IDLE;
         end
      endcase
      // stop beats start when both bits are written together
      if (cmd_stop) begin
         nxt_state = S_IDLE;
         nxt_cnt   = `GDPG_CNT_RST;
      end else if (cmd_start) begin
         nxt_done = 1'b0;
         if (edge_mode) begin
            nxt_state = S_ARMED;
            nxt_cnt   = `GDPG_CNT_RST;
         end else begin
            nxt_state = S_DELAY;
            nxt_cnt   = eff_len(delay_ff, cfg_tb);
         end
      end
   end

   // output level: delay level is the polarity bit, width level its inverse
   always @* begin
      if (cmd_stop) begin
         nxt_out = cfg_pol;
      end else if (cmd_start) begin
         nxt_out = cfg_pol;
      end else if (state_ff == S_IDLE) begin
         nxt_out = cfg_pol;
      end else begin
         nxt_out = run_pol_ff ^ (nxt_state == S_WIDTH);
      end
   end

   // state registers; run configuration is latched at start so a later
   // rewrite of the control register cannot disturb a pulse in flight
   always @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         state_ff     <= S_IDLE;
         cnt_ff       <= `GDPG_CNT_RST;
         done_ff      <= 1'b0;
         out_ff       <= `GDPG_POL_HIGH_PULSE;
         run_gate_ff  <= `GDPG_GATE_NONE;
         run_pol_ff   <= `GDPG_POL_HIGH_PULSE;
         run_tb_ff    <= `GDPG_TB_INTERNAL;
         run_width_ff <= `GDPG_CNT_RST;
      end else if (ce) begin
         state_ff <= nxt_state;
         cnt_ff   <= nxt_cnt;
         done_ff  <= nxt_done;
         out_ff   <= nxt_out;
         if (cmd_start && !cmd_stop) begin
            run_gate_ff  <= cfg_gate;
            run_pol_ff   <= cfg_pol;
            run_tb_ff    <= cfg_tb;
            run_width_ff <= width_ff;
         end
      end
   end

   assign pulse_output = out_ff;

endmodule // gdpg_top

`default_nettype wire

// ===== gdpg_gate_src.sv
/* far-side model: gate level source and external timebase for the pulse generator.
   assumes: driven by the bench; outputs change just after the rising clock edge. */
`timescale 1ns/1ps
`default_nettype none
module gdpg_gate_src (
   input  wire logic ref_clk,                  // system clock
   input  wire logic rstn,                     // async reset, active low
   input  wire logic gate_req,                 // gate level asked for by the bench
   input  wire logic tick_en,                  // lets the external timebase run
   output var  logic gate_input,               // gate pin
   output var  logic external_timebase_input   // timebase pin, a tick every 4 clocks
);
   logic [1:0] div_ff;
   // -------------------------------------------------------------------------
   // registered pins, so the design never sees a change at its own edge
   // -------------------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         div_ff <= 2'h0;
         gate_input <= 1'b0;
         external_timebase_input <= 1'b0;
      end else begin
         div_ff <= div_ff + 2'h1;
         gate_input <= gate_req;
         external_timebase_input <= tick_en & div_ff[1];   // stands low when stopped
      end
   end
endmodule // gdpg_gate_src
`default_nettype wire

// ===== gdpg_monitor.sv
/* assertion checker for the pulse generator top, bound to gdpg_top.
   assumes: one clock domain; it shadows the register writes it needs. */
`timescale 1ns/1ps
`default_nettype none
module gdpg_monitor (
   input wire logic        ref_clk,       // clock
   input wire logic        rstn,          // reset, active low
   input wire logic        ce,            // clock enable
   input wire logic        hsel,          // ahb select
   input wire logic [31:0] haddr,         // ahb address
   input wire logic [1:0]  htrans,        // ahb transfer type
   input wire logic        hwrite,        // ahb write
   input wire logic [31:0] hwdata,        // ahb write data
   input wire logic        hready,        // ahb ready
   input wire logic        hreadyout,     // slave ready
   input wire logic        hresp,         // slave response
   input wire logic [31:0] hrdata,        // read data
   input wire logic        gate_input,    // gate pin
   input wire logic        pulse_output   // pulse pin
);
   logic [7:0]  pa_ff;
   logic        pw_ff, go_ff, lpol_ff;
   logic [4:0]  ctl_ff;
   logic [31:0] dly_ff, wid_ff, cnt_ff, ed_ff, ew_ff;
   wire take = hsel & htrans[1] & hready & ce;
   wire cmd_w = pw_ff & ce & (pa_ff == 8'h0C);
   wire start_w = cmd_w & hwdata[0] & !hwdata[1];
   wire edge_md = (ctl_ff[2:0] == 3'h3) | (ctl_ff[2:0] == 3'h4);
   // -------------------------------------------------------------------------
   // shadow registers and a cycle count from start (timed runs: mode 0 or 5 to 7, int)
   // -------------------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         {pa_ff, pw_ff, go_ff, lpol_ff, ctl_ff} <= 16'h0000;
         {dly_ff, wid_ff, cnt_ff, ed_ff, ew_ff} <= 160'h0;
      end else if (ce) begin
         pw_ff <= take & hwrite;
         if (take) pa_ff <= haddr[7:0];
         if (pw_ff && pa_ff == 8'h00) ctl_ff <= hwdata[4:0];
         if (pw_ff && pa_ff == 8'h04) dly_ff <= hwdata;
         if (pw_ff && pa_ff == 8'h08) wid_ff <= hwdata;
         cnt_ff <= cnt_ff + 32'h1;
         if (cmd_w) begin
            go_ff <= start_w & !ctl_ff[4] & (ctl_ff[2:0] == 3'h0 || ctl_ff[2:0] > 3'h4);
            lpol_ff <= ctl_ff[3];
            cnt_ff <= 32'h0;
            ed_ff <= (dly_ff == 32'h0) ? 32'h3 : dly_ff;   // zero counts are raised to three
            ew_ff <= (wid_ff == 32'h0) ? 32'h3 : wid_ff;
         end
      end else begin
         go_ff <= 1'b0;   // a stall spoils the count, so stop judging this run
      end
   end
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rstn);
   sequence s_lvl_start;
      start_w && (ctl_ff[2:0] < 3'h3 || ctl_ff[2:0] > 3'h4);
   endsequence
   sequence s_still;
      $stable(gate_input) [*4];
   endsequence
   a_resp_okay: assert property (hresp == 1'b0) else $error("response not okay");
   a_ready_ce: assert property (hreadyout == ce) else $error("ready does not follow enable");
   a_rdata_hold: assert property (!(take && !hwrite) |=> $stable(hrdata)) else $error("read data moved");
   a_start_level: assert property (s_lvl_start |=> pulse_output == lpol_ff)
      else $error("wrong level after start");
   a_delay_phase: assert property (go_ff && cnt_ff < ed_ff |-> pulse_output == lpol_ff)
      else $error("delay phase level wrong");
   a_width_phase: assert property (go_ff && cnt_ff >= ed_ff && cnt_ff < ed_ff + ew_ff
      |-> pulse_output != lpol_ff) else $error("width phase level wrong");
   a_after_done: assert property (go_ff && cnt_ff >= ed_ff + ew_ff |-> pulse_output == lpol_ff)
      else $error("level after pulse wrong");
   a_armed_hold: assert property (start_w && edge_md ##1 s_still |-> pulse_output == lpol_ff)
      else $error("pulse left armed without edge");
endmodule // gdpg_monitor
bind gdpg_top gdpg_monitor gdpg_monitor_i (.ref_clk, .rstn, .ce, .hsel, .haddr, .htrans, .hwrite, .hwdata,
   .hready, .hreadyout, .hresp, .hrdata, .gate_input, .pulse_output);
`default_nettype wire

// ===== gdpg_top_bench.sv
/* self-checking bench: ahb master tasks, a cycle model of the generator, random gate.
   assumes: gdpg_top, gdpg_gate_src and the bound checker are compiled with it. */
`timescale 1ns/1ps
`default_nettype none
module gdpg_top_bench;
   logic        ref_clk, rstn, ce, hsel, hwrite, gate_req, tick_en, adv, m_pw, g_prev, x_prev, l_pol, l_tb, m_dn;
   logic [31:0] haddr, hwdata, rd, rv, d, w, m_dly, m_wid, l_w;
   logic [1:0]  htrans;
   logic [2:0]  hsize, l_gate;
   logic [4:0]  m_ctl, ctl;
   logic [7:0]  m_pa;
   wire         hreadyout, hresp, gate_input, external_timebase_input, pulse_output;
   wire  [31:0] hrdata;
   int          n_fail, samples_checked, seed, m_st, m_cnt;
   logic [7:0]  regs [6] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h14, 8'h20};
   gdpg_top gdpg_top_i (.ref_clk(ref_clk), .rstn(rstn), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata), .gate_input(gate_input), .external_timebase_input(external_timebase_input),
      .pulse_output(pulse_output));
   gdpg_gate_src gdpg_gate_src_i (.ref_clk(ref_clk), .rstn(rstn), .gate_req(gate_req), .tick_en(tick_en),
      .gate_input(gate_input), .external_timebase_input(external_timebase_input));
   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end
   // -------------------------------------------------------------------------
   // helpers: compare, verdict, bounded ready wait, one ahb single transfer
   // -------------------------------------------------------------------------
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic wait_ready;
      int k;
      k = 0;
      do begin
         @(posedge ref_clk);
         k++;
      end while (hreadyout !== 1'b1 && k < 20);
      if (hreadyout !== 1'b1) begin
         n_fail++;
         report_and_stop;
      end
   endtask
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, input int st);
      @(posedge ref_clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr <= {24'h000000, a};
      if (st > 0) begin   // enable low stalls the slave; the address must stay put
         ce <= 1'b0;
         repeat (st) @(posedge ref_clk);
         ce <= 1'b1;
      end
      wait_ready;
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      wait_ready;
      rd = hrdata;
   endtask
   function automatic int eff(input logic [31:0] c);
      return (c == 32'h0) ? (l_tb ? 1 : 3) : int'(c);
   endfunction
   function automatic logic [31:0] stat_exp();
      logic o;
      o = (m_st == 0) ? m_ctl[3] : (m_st == 3) ? !l_pol : l_pol;
      return {26'h0, m_dn, m_st > 0 && m_st < 4, o, m_st[2:0]};
   endfunction
   // -------------------------------------------------------------------------
   // cycle model: 0 idle, 1 armed, 2 delay, 3 width, 4 done
   // -------------------------------------------------------------------------
   always @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         {m_st, m_ctl, m_dly, m_wid, m_pw, g_prev, x_prev, m_dn} = 0;
      end else if (ce) begin
         adv = (l_tb ? external_timebase_input & !x_prev : 1'b1) &&
               (l_gate == 3'h1 ? gate_input : l_gate == 3'h2 ? !gate_input : 1'b1);
         if (m_st == 1 && gate_input != g_prev && gate_input == (l_gate == 3'h3)) begin
            m_st = 2;
            m_cnt = eff(m_dly);
         end else if ((m_st == 2 || m_st == 3) && adv && --m_cnt == 0) begin
            m_st++;
            m_cnt = eff(l_w);
            m_dn |= (m_st == 4);   // done sticks through a stop, only a start clears it
         end
         if (m_pw) begin
            case (m_pa)
               8'h00: m_ctl = hwdata[4:0];
               8'h04: m_dly = hwdata;
               8'h08: m_wid = hwdata;
               8'h0C: if (hwdata[1]) m_st = 0;
                      else if (hwdata[0]) begin
                         l_gate = (m_ctl[2:0] > 3'h4) ? 3'h0 : m_ctl[2:0];
                         {l_tb, l_pol} = m_ctl[4:3];
                         l_w = m_wid;
                         m_dn = 1'b0;
                         m_st = (l_gate > 3'h2) ? 1 : 2;
                         m_cnt = eff(m_dly);
                      end
               default: ;
            endcase
         end
         m_pw = hsel & htrans[1] & hwrite;
         if (hsel && htrans[1]) m_pa = haddr[7:0];
         g_prev = gate_input;
         x_prev = external_timebase_input;
      end
   end
   always @(negedge ref_clk)
      if (rstn && m_st != 0)
         check("pulse", {31'h0, pulse_output}, {31'h0, m_st == 3 ? !l_pol : l_pol});
   // -------------------------------------------------------------------------
   // main sequence
   // -------------------------------------------------------------------------
   initial begin
      {n_fail, samples_checked} = 0;
      seed = 32'hBC55;
      {rstn, hsel, hwrite, gate_req, tick_en, htrans, haddr, hwdata} = 0;
      ce = 1'b1;
      hsize = 3'h2;
      repeat (4) @(posedge ref_clk);
      rstn <= 1'b1;
      tick_en <= 1'b1;
      @(negedge ref_clk);
      check("pulse after reset", {31'h0, pulse_output}, 32'h0);
      for (int j = 0; j < 6; j++) begin
         bus(1'b0, regs[j], 32'h0, (j == 2) ? 3 : 0);
         check("reset value", rd, 32'h0);
      end
      for (int j = 0; j < 6; j++) begin   // random write then read back, unmapped stays zero
         rv = $random(seed);
         bus(1'b1, regs[j], rv, 0);
         bus(1'b0, regs[j], 32'h0, 0);
         check("readback", rd, j == 0 ? {27'h0, rv[4:0]} : j == 3 ? stat_exp() : j > 2 ? 32'h0 : rv);
      end
      for (int i = 0; i < 12; i++) begin
         ctl = {1'(i >= 8), 1'(i >= 6), 3'(i % 6)};
         d = (i % 3 == 0) ? 32'h0 : 32'($random(seed) & 7);
         w = (i % 4 == 1) ? 32'h0 : 32'($random(seed) & 7);
         bus(1'b1, 8'h00, {27'h0, ctl}, 0);
         bus(1'b1, 8'h04, d, 0);
         bus(1'b1, 8'h08, w, 0);
         bus(1'b1, 8'h0C, 32'h1, 0);
         if (i == 7) bus(1'b1, 8'h0C, 32'h1, 0);   // restart in mid run
         repeat (200) begin
            @(posedge ref_clk);
            if (($random(seed) & 7) == 0) gate_req <= !gate_req;
         end
         if (i == 5) bus(1'b1, 8'h0C, 32'h3, 0);   // stop wins over start
         @(negedge ref_clk);
         rv = stat_exp();   // snapshot off the edge; idle and done stand until the next command
         bus(1'b0, 8'h10, 32'h0, 0);
         if (!rv[4]) check("status", rd, rv);
      end
      report_and_stop;
   end
endmodule // gdpg_top_bench
`default_nettype wire
